//--- pkg/dsc_defines.svh
`ifndef DSC_DEFINES_SVH
`define DSC_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets on the APB bus
// ----------------------------------------------------------------
`define DSC_OFS_CTRL    8'h00
`define DSC_OFS_MAR     8'h04
`define DSC_OFS_FIXED_IO_ADDRESS_REG    8'h08
`define DSC_OFS_COUNT   8'h0c
`define DSC_OFS_STAT    8'h10

// ----------------------------------------------------------------
// Widths, reset values and fixed values
// ----------------------------------------------------------------
`define DSC_PADDR_W     8
`define DSC_ADDR_W      24
`define DSC_COUNT_W     16
`define DSC_CTRL_RST    8'h00
`define DSC_IO_UPPER    16'hffff
`define DSC_STEP_BYTE   24'h000001
`define DSC_STEP_WORD   24'h000002
`define DSC_COUNT_ZERO  16'h0000
`define DSC_COUNT_ONE   16'h0001
`define DSC_BYTE_ZERO   8'h00
`define DSC_BYTE_ONE    8'h01

// ----------------------------------------------------------------
// Activation source codes
// ----------------------------------------------------------------
`define DSC_SRC_TMR_MAX 3'h3
`define DSC_SRC_SCI_TXE 3'h4
`define DSC_SRC_SCI_RXF 3'h5
`define DSC_SRC_EXT_FALL 3'h6
`define DSC_SRC_EXT_LOW 3'h7

`endif

//--- pkg/dsc_pkg.sv
`include "dsc_defines.svh"

package dsc_pkg;

  // ----------------------------------------------------------------
  // Channel transfer control register layout
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       channel_enable_bit;     // Bit 7
    logic       transfer_size_bit;      // Bit 6, word when set
    logic       address_direction_bit;  // Bit 5, decrement when set
    logic       repeat_select_bit;      // Bit 4
    logic       completion_irq_enable;  // Bit 3
    logic [2:0] source_select;          // Bits 2..0
  } dsc_ctrl_t;

  // Operating modes
  typedef enum logic [2:0] {
    DSC_MODE_IO     = 3'b001,
    DSC_MODE_REPEAT = 3'b010,
    DSC_MODE_IDLE   = 3'b100
  } dsc_mode_t;

  // One transfer handed to the bus engine
  typedef struct packed {
    logic [`DSC_ADDR_W-1:0] src_addr;   // Source address
    logic [`DSC_ADDR_W-1:0] dst_addr;   // Destination address
    logic                   word;       // Word size when set
  } dsc_xfer_t;

  // Mode from repeat and interrupt enable bits
  function automatic dsc_mode_t dsc_mode_f(input dsc_ctrl_t c);
    if (!c.repeat_select_bit) begin
      return DSC_MODE_IO;
    end
    return c.completion_irq_enable ? DSC_MODE_IDLE : DSC_MODE_REPEAT;
  endfunction : dsc_mode_f

endpackage : dsc_pkg

//--- logic/dsc_step.sv
`include "dsc_defines.svh"

// Next memory address and count after one finished transfer
module dsc_step (
  input  wire dsc_pkg::dsc_ctrl_t         i_ctrl,
  input  wire logic [`DSC_ADDR_W-1:0]     i_mar,
  input  wire logic [`DSC_COUNT_W-1:0]    i_count,
  output logic      [`DSC_ADDR_W-1:0]     o_next_mar,
  output logic      [`DSC_COUNT_W-1:0]    o_next_count,
  output logic                            o_last
);
  import dsc_pkg::*;

  dsc_mode_t              mode;   // Decoded mode
  logic [`DSC_ADDR_W-1:0] step;   // Address step
  logic [7:0]             hi_dec; // Upper count byte minus one

  // ----------------------------------------------------------------
  // Address and count stepping
  // ----------------------------------------------------------------
  always_comb begin
    mode = dsc_mode_f(i_ctrl);                                 // RL10
    step = i_ctrl.transfer_size_bit ? `DSC_STEP_WORD
                                    : `DSC_STEP_BYTE;          // RL7
    hi_dec = i_count[15:8] - `DSC_BYTE_ONE;
    // Idle mode holds the address
    if (mode == DSC_MODE_IDLE) begin
      o_next_mar = i_mar;                                      // RL9
    end else if (i_ctrl.address_direction_bit) begin
      o_next_mar = i_mar - step;                               // RL8
    end else begin
      o_next_mar = i_mar + step;                               // RL8
    end
    // Repeat mode: upper byte counts and reloads from lower byte
    if (mode == DSC_MODE_REPEAT) begin
      o_last = 1'b0;                                           // RL21
      if (hi_dec == `DSC_BYTE_ZERO) begin
        o_next_count = {i_count[7:0], i_count[7:0]};           // RL20
      end else begin
        o_next_count = {hi_dec, i_count[7:0]};                 // RL20
      end
    end else begin
      o_next_count = i_count - `DSC_COUNT_ONE;                 // RL19
      o_last = (o_next_count == `DSC_COUNT_ZERO);              // RL19
    end
  end

endmodule : dsc_step

//--- logic/dsc_channel.sv
// Summary of operation
// [RL1] Reset and standby clear control to zero
// [RL2] Enabled channel transfers on each chosen event
// [RL3] Disabled channel ignores every request
// [RL4] Enable sets only after reading it clear
// [RL5] I/O and idle modes clear enable at end
// [RL6] Enable clearing raises completion interrupt if enabled
// [RL7] Size bit picks byte or word
// [RL8] Address steps up or down by size
// [RL9] Idle mode never steps the address
// [RL10] Repeat and interrupt bits choose the mode
// [RL11] Codes zero to three pick timer events
// [RL12] Codes four, five pick serial empty/full
// [RL13] Channel B codes six, seven: external request
// [RL14] Channel A codes six, seven: pair mode
// [RL15] Shared events serviced by fixed priority
// [RL16] Enabled channel masks its source interrupt
// [RL17] Receive-full source writes to memory
// [RL18] I/O address upper bits ones, never stepped
// [RL19] Count decrements, ends at zero
// [RL20] Repeat upper byte reloads from lower byte
// [RL21] Repeat mode keeps enable set on reload
//
// The implementer's own choices: the address map and register access over APB.
`include "dsc_defines.svh"

module dsc_channel #(
  parameter bit IS_CHAN_B = 1'b1   // Channel B has the external request
) (
  input  wire logic                      i_mclk,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_standby,
  input  wire logic                      i_psel,
  input  wire logic                      i_penable,
  input  wire logic                      i_pwrite,
  input  wire logic [`DSC_PADDR_W-1:0]   i_paddr,
  input  wire logic [31:0]               i_pwdata,
  output logic      [31:0]               o_prdata,
  output logic                           o_pready,
  output logic                           o_pslverr,
  input  wire logic [3:0]                i_tmr_match,
  input  wire logic                      i_sci_txe,
  input  wire logic                      i_sci_rxf,
  input  wire logic                      i_external_request_input_n,
  output logic                           o_xfer_req,
  output dsc_pkg::dsc_xfer_t             o_xfer,
  input  wire logic                      i_xfer_grant,
  input  wire logic                      i_xfer_done,
  output logic                           o_completion_interrupt,
  output logic      [7:0]                o_irq_block,
  output logic                           o_pair_mode
);
  import dsc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DSC_ST_IDLE = 3'b001,   // Waiting for a request
    DSC_ST_REQ  = 3'b010,   // Asking the arbiter
    DSC_ST_BUSY = 3'b100    // Transfer on the bus
  } dsc_state_t;

  dsc_ctrl_t                 ctrl;          // Control register
  dsc_ctrl_t                 next_ctrl;     // Control next value
  logic [`DSC_ADDR_W-1:0]    mar;           // Memory address
  logic [7:0]                fixed_io_address_reg;          // Fixed I/O address low byte
  logic [`DSC_COUNT_W-1:0]   count;         // Transfer count
  logic                      armed;         // Enable read as zero
  logic                      pending;       // Request waiting
  dsc_state_t                state;         // Transfer state
  logic [2:0]                ext_sync;      // External pin synchroniser
  logic                      ext_lvl;       // Filtered pin level
  logic                      ext_lvl_q;     // Filtered level, delayed
  logic                      event_hit;     // Selected source fired
  logic                      step_now;      // Transfer finished
  logic [`DSC_ADDR_W-1:0]    step_mar;      // Stepped address
  logic [`DSC_COUNT_W-1:0]   step_count;    // Stepped count
  logic                      step_last;     // Count reached zero
  logic                      acc;           // APB access phase
  logic                      wr_ctrl;       // Control write
  logic                      pair_code;     // Channel A pair mode code

  initial begin
    assert (`DSC_PADDR_W >= 5) else $error("Address width too small");
  end

  // Address decode
  function automatic logic dsc_mapped_f(input logic [`DSC_PADDR_W-1:0] a);
    return a == `DSC_OFS_CTRL || a == `DSC_OFS_MAR || a == `DSC_OFS_FIXED_IO_ADDRESS_REG
        || a == `DSC_OFS_COUNT || a == `DSC_OFS_STAT;
  endfunction : dsc_mapped_f

  // ----------------------------------------------------------------
  // APB handshake and read data
  // ----------------------------------------------------------------
  assign acc       = i_psel & i_penable;
  assign o_pready  = 1'b1;
  assign o_pslverr = acc & ~dsc_mapped_f(i_paddr);
  assign wr_ctrl   = acc & i_pwrite & (i_paddr == `DSC_OFS_CTRL);

  // Read data captured in the setup cycle
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      unique case (i_paddr)
        `DSC_OFS_CTRL:  o_prdata <= {24'h00_0000, ctrl};
        `DSC_OFS_MAR:   o_prdata <= {8'h00, mar};
        `DSC_OFS_FIXED_IO_ADDRESS_REG:  o_prdata <= {24'h00_0000, fixed_io_address_reg};
        `DSC_OFS_COUNT: o_prdata <= {16'h0000, count};
        `DSC_OFS_STAT:  o_prdata <= {26'h000_0000, ext_lvl, pending,
                                     armed, state};
        default:        o_prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl = dsc_ctrl_t'(i_pwdata[7:0]);
      // Setting enable needs a prior read with enable clear
      next_ctrl.channel_enable_bit = i_pwdata[7]
        & (armed | ctrl.channel_enable_bit);                   // RL4
    end
    // Finished count ends I/O and idle mode
    if (step_now && step_last) begin
      next_ctrl.channel_enable_bit = 1'b0;                     // RL5
    end
    if (i_standby) begin
      next_ctrl = dsc_ctrl_t'(`DSC_CTRL_RST);                  // RL1
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl <= dsc_ctrl_t'(`DSC_CTRL_RST);                      // RL1
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // Completion pulse on each clearing of enable while the completion interrupt is enabled
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_completion_interrupt <= 1'b0;
    end else begin
      o_completion_interrupt <= ctrl.channel_enable_bit
        & ~next_ctrl.channel_enable_bit
        & ctrl.completion_irq_enable;                          // RL6
    end
  end

  // Read-before-set arming
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      armed <= 1'b0;
    end else if (wr_ctrl || i_standby) begin
      armed <= 1'b0;
    end else if (acc && !i_pwrite && i_paddr == `DSC_OFS_CTRL
                 && !ctrl.channel_enable_bit) begin
      armed <= 1'b1;                                           // RL4
    end
  end

  // ----------------------------------------------------------------
  // Address and count registers
  // ----------------------------------------------------------------
  dsc_step u_step (
    .i_ctrl       (ctrl),
    .i_mar        (mar),
    .i_count      (count),
    .o_next_mar   (step_mar),
    .o_next_count (step_count),
    .o_last       (step_last)
  );

  assign step_now = (state == DSC_ST_BUSY) & i_xfer_done;

  // Software write wins over a step in the same cycle
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mar   <= '0;
      fixed_io_address_reg  <= 8'h00;
      count <= `DSC_COUNT_ZERO;
    end else begin
      if (acc && i_pwrite && i_paddr == `DSC_OFS_MAR) begin
        mar <= i_pwdata[`DSC_ADDR_W-1:0];
      end else if (step_now) begin
        mar <= step_mar;                                       // RL8
      end
      if (acc && i_pwrite && i_paddr == `DSC_OFS_FIXED_IO_ADDRESS_REG) begin
        fixed_io_address_reg <= i_pwdata[7:0];                                 // RL18
      end
      if (acc && i_pwrite && i_paddr == `DSC_OFS_COUNT) begin
        count <= i_pwdata[`DSC_COUNT_W-1:0];
      end else if (step_now) begin
        count <= step_count;                                   // RL19
      end
    end
  end

  // ----------------------------------------------------------------
  // External request pin
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_sync  <= 3'b111;
      ext_lvl   <= 1'b1;
      ext_lvl_q <= 1'b1;
    end else begin
      ext_sync  <= {ext_sync[1:0], i_external_request_input_n};
      if (ext_sync[1] == ext_sync[2]) begin
        ext_lvl <= ext_sync[2];
      end
      ext_lvl_q <= ext_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Activation source select
  // ----------------------------------------------------------------
  assign pair_code = ~IS_CHAN_B & ctrl.source_select[2]
                   & ctrl.source_select[1];                    // RL14
  assign o_pair_mode = pair_code;

  always_comb begin
    unique case (ctrl.source_select)
      3'h0, 3'h1, 3'h2, 3'h3:
        event_hit = i_tmr_match[ctrl.source_select[1:0]];      // RL11
      `DSC_SRC_SCI_TXE: event_hit = i_sci_txe;                 // RL12
      `DSC_SRC_SCI_RXF: event_hit = i_sci_rxf;                 // RL12
      `DSC_SRC_EXT_FALL:
        event_hit = IS_CHAN_B & ext_lvl_q & ~ext_lvl;          // RL13
      `DSC_SRC_EXT_LOW:
        event_hit = IS_CHAN_B & ~ext_lvl;                      // RL13
    endcase
  end

  // Selected source cannot interrupt the CPU while enabled
  always_comb begin
    o_irq_block = 8'h00;
    if (ctrl.channel_enable_bit && !pair_code) begin
      o_irq_block[ctrl.source_select] = 1'b1;                  // RL16
    end
  end

  // Pending request; a new event wins over the clear at transfer end
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pending <= 1'b0;
    end else if (!ctrl.channel_enable_bit || pair_code
                 || !next_ctrl.channel_enable_bit) begin
      pending <= 1'b0;                                         // RL3
    end else if (event_hit) begin
      pending <= 1'b1;                                         // RL2
    end else if (step_now) begin
      pending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transfer sequencing
  // ----------------------------------------------------------------
  // Arbiter grants one channel at a time in priority order
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= DSC_ST_IDLE;
    end else begin
      unique case (state)
        DSC_ST_IDLE: if (pending && ctrl.channel_enable_bit) begin
          state <= DSC_ST_REQ;                                 // RL2
        end
        DSC_ST_REQ: if (!ctrl.channel_enable_bit) begin
          state <= DSC_ST_IDLE;                                // RL3
        end else if (i_xfer_grant) begin
          state <= DSC_ST_BUSY;                                // RL15
        end
        DSC_ST_BUSY: if (i_xfer_done) begin
          state <= DSC_ST_IDLE;
        end
      endcase
    end
  end

  assign o_xfer_req = (state == DSC_ST_REQ) & ctrl.channel_enable_bit;

  // Transfer addresses, held in flops
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_xfer <= '0;
    end else if (state == DSC_ST_IDLE) begin
      o_xfer.word <= ctrl.transfer_size_bit;                   // RL7
      if (ctrl.source_select == `DSC_SRC_SCI_RXF) begin
        o_xfer.src_addr <= {`DSC_IO_UPPER, fixed_io_address_reg};              // RL17
        o_xfer.dst_addr <= mar;                                // RL17
      end else begin
        o_xfer.src_addr <= mar;                                // RL17
        o_xfer.dst_addr <= {`DSC_IO_UPPER, fixed_io_address_reg};              // RL18
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking dsc_cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence s_ready;
    state == DSC_ST_IDLE && pending && ctrl.channel_enable_bit
      && !i_standby && !wr_ctrl;
  endsequence
  sequence s_last_step;
    step_now && step_last && !i_standby;
  endsequence

  standby_clear_a: assert property (i_standby |=> ctrl == 8'h00) // RL1
    else $error("Control not cleared by standby");
  start_req_a: assert property (s_ready |=> o_xfer_req)          // RL2
    else $error("Enabled pending channel did not request");
  no_req_off_a: assert property (!ctrl.channel_enable_bit
    |-> !o_xfer_req && !pending)                                 // RL3
    else $error("Disabled channel requests");
  set_after_read_a: assert property ($rose(ctrl.channel_enable_bit)
    |-> $past(armed))                                            // RL4
    else $error("Enable set without prior read");
  auto_clear_a: assert property (s_last_step
    |=> !ctrl.channel_enable_bit)                                // RL5
    else $error("Enable kept after final transfer");
  irq_on_clear_a: assert property ($fell(ctrl.channel_enable_bit)
    && $past(ctrl.completion_irq_enable)
    |-> o_completion_interrupt)                                  // RL6
    else $error("Completion interrupt missing");
  byte_up_a: assert property (step_now && !ctrl.repeat_select_bit
    && !ctrl.address_direction_bit && !ctrl.transfer_size_bit
    && !(acc && i_pwrite)
    |=> mar == $past(mar) + 24'h000001)                          // RL8
    else $error("Byte increment wrong");
  idle_hold_a: assert property (step_now
    && dsc_mode_f(ctrl) == DSC_MODE_IDLE && !(acc && i_pwrite)
    |=> mar == $past(mar))                                       // RL9
    else $error("Idle mode stepped the address");
  repeat_keep_a: assert property (step_now
    && dsc_mode_f(ctrl) == DSC_MODE_REPEAT && !wr_ctrl && !i_standby
    |=> ctrl.channel_enable_bit)                                 // RL21
    else $error("Repeat mode dropped enable");
  src_mask_a: assert property (ctrl.channel_enable_bit && !pair_code
    |-> o_irq_block[ctrl.source_select])                         // RL16
    else $error("Source interrupt not masked");

endmodule : dsc_channel

//--- tb/dsc_src_model.sv
// Event sources and bus arbiter seen by one channel
module dsc_src_model (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_fire,     // One event of the chosen source
  input  wire logic [2:0] i_code,     // Source that fires
  input  wire logic       i_hold_low, // Keep request pin low
  input  wire logic       i_slow,     // Late transfer completion
  input  wire logic       i_xfer_req,
  output logic      [3:0] o_tmr_match,
  output logic            o_sci_txe,
  output logic            o_sci_rxf,
  output logic            o_ext_n,
  output logic            o_grant,
  output logic            o_done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] low_cnt;  // Pin low time for an edge request
  logic [1:0] wait_cnt; // Cycles left before done
  logic       busy;     // Transfer granted, not yet done
  // Pin has a pull-up: high whenever nobody pulls it
  assign o_ext_n = !(i_hold_low || low_cnt != 4'h0);
  // One-cycle event pulses on the chosen source; code six pulls the pin low for eight cycles
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tmr_match <= 4'h0;
      o_sci_txe   <= 1'b0;
      o_sci_rxf   <= 1'b0;
      low_cnt     <= 4'h0;
    end else begin
      o_tmr_match <= (i_fire && !i_code[2]) ? 4'h1 << i_code[1:0] : 4'h0;
      o_sci_txe   <= i_fire && i_code == 3'h4;
      o_sci_rxf   <= i_fire && i_code == 3'h5;
      if (i_fire && i_code == 3'h6) begin
        low_cnt <= 4'h8;
      end else if (low_cnt != 4'h0) begin
        low_cnt <= low_cnt - 4'h1;
      end
    end
  end
  // Grant then done, promptly or after a stall
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_grant  <= 1'b0;
      o_done   <= 1'b0;
      busy     <= 1'b0;
      wait_cnt <= 2'h0;
    end else begin
      o_grant <= 1'b0;
      o_done  <= 1'b0;
      if (!busy && !o_grant && i_xfer_req) begin
        o_grant  <= 1'b1;
        busy     <= 1'b1;
        wait_cnt <= i_slow ? 2'h3 : 2'h0;
      end else if (busy && !o_grant) begin
        if (wait_cnt == 2'h0) begin
          o_done <= 1'b1;
          busy   <= 1'b0;
        end else begin
          wait_cnt <= wait_cnt - 2'h1;
        end
      end
    end
  end
endmodule : dsc_src_model

//--- tb/dsc_short_channel_control_tb.sv
module dsc_short_channel_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dsc_pkg::*;
  logic mclk, rst_n, standby, psel, penable, pwrite, fire, hold, slow;
  logic pready, pslverr, perr, xreq, grant, done, cirq, txe, rxf, ext_n, pair;
  logic [7:0]  paddr, blk;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  tmr;
  logic [2:0]  code;
  dsc_xfer_t   xf, last_x;
  int failures = 0, n_compared = 0, n_done = 0, n_irq = 0;
  logic [2:0] c_list [5] = '{3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
  dsc_channel i_dsc_channel (.i_mclk(mclk), .i_rst_n(rst_n),
    .i_standby(standby), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_tmr_match(tmr), .i_sci_txe(txe), .i_sci_rxf(rxf),
    .i_external_request_input_n(ext_n), .o_xfer_req(xreq), .o_xfer(xf),
    .i_xfer_grant(grant), .i_xfer_done(done),
    .o_completion_interrupt(cirq), .o_irq_block(blk), .o_pair_mode(pair));
  dsc_src_model i_dsc_src_model (.i_mclk(mclk), .i_rst_n(rst_n),
    .i_fire(fire), .i_code(code), .i_hold_low(hold), .i_slow(slow),
    .i_xfer_req(xreq), .o_tmr_match(tmr), .o_sci_txe(txe),
    .o_sci_rxf(rxf), .o_ext_n(ext_n), .o_grant(grant), .o_done(done));
  // Clock at 250 MHz
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Count finished transfers and completion pulses
  always @(posedge mclk) begin
    if (done === 1'b1) n_done++;
    if (cirq === 1'b1) n_irq++;
    if (grant === 1'b1) last_x <= xf;
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    int k;
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (k == 50) begin
      failures++;
      report_and_stop;
    end
    rd = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input string nm, input logic [7:0] a, input int e);
    apb(1'b0, a, 0);
    chk(nm, e, rd);
  endtask : rdc
  // Arming read, then the write that may set the enable
  task automatic set_ctrl(input int v);
    apb(1'b0, 8'h00, 0);
    apb(1'b1, 8'h00, v);
    // Let the new control value settle before outputs are read
    @(posedge mclk);
  endtask : set_ctrl
  // Fire one event and wait for its transfer to finish
  task automatic ev(input logic [2:0] c, input logic pulse);
    int k;
    int t;
    t = n_done + 1;
    @(posedge mclk);
    code <= c;
    fire <= pulse;
    hold <= !pulse;
    @(posedge mclk);
    fire <= 1'b0;
    for (k = 0; k < 300 && n_done < t; k++) @(posedge mclk);
    hold <= 1'b0;
    if (k == 300) begin
      failures++;
      report_and_stop;
    end
  endtask : ev
  task automatic t_regs;
    apb(1'b1, 8'h00, 32'h80);
    rdc("ctrl", 8'h00, 0);
    apb(1'b0, 8'h14, 0);
    chk("pslverr", 1, perr);
    apb(1'b1, 8'h00, 32'h80);
    rdc("ctrl", 8'h00, 32'h80);
    apb(1'b1, 8'h00, 0);
    apb(1'b1, 8'h08, 32'h34);
    $display("test regs done");
  endtask : t_regs
  task automatic t_io;
    apb(1'b1, 8'h04, 32'h100);
    apb(1'b1, 8'h0c, 2);
    set_ctrl(32'h88);
    chk("irq_block", 1, blk);
    ev(3'h0, 1'b1);
    ev(3'h0, 1'b1);
    chk("src", 32'h101, last_x.src_addr);
    chk("dst", 32'hffff34, last_x.dst_addr);
    chk("word", 0, last_x.word);
    rdc("mar", 8'h04, 32'h102);
    rdc("count", 8'h0c, 0);
    rdc("ctrl", 8'h00, 32'h08);
    chk("irqs", 1, n_irq);
    $display("test io done");
  endtask : t_io
  task automatic t_idle;
    apb(1'b1, 8'h04, 32'h200);
    apb(1'b1, 8'h0c, 1);
    set_ctrl(32'h9d);
    ev(3'h5, 1'b1);
    chk("src", 32'hffff34, last_x.src_addr);
    chk("dst", 32'h200, last_x.dst_addr);
    rdc("mar", 8'h04, 32'h200);
    rdc("ctrl", 8'h00, 32'h1d);
    chk("irqs", 2, n_irq);
    $display("test idle done");
  endtask : t_idle
  task automatic t_repeat;
    int n;
    slow <= 1'b1;
    apb(1'b1, 8'h04, 32'h300);
    apb(1'b1, 8'h0c, 32'h0202);
    set_ctrl(32'hf1);
    chk("irq_block", 2, blk);
    for (n = 0; n < 3; n++) ev(3'h1, 1'b1);
    chk("word", 1, last_x.word);
    rdc("mar", 8'h04, 32'h2fa);
    rdc("count", 8'h0c, 32'h0102);
    rdc("ctrl", 8'h00, 32'hf1);
    chk("irqs", 2, n_irq);
    apb(1'b1, 8'h00, 32'h71);
    n = n_done;
    @(posedge mclk);
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    repeat (20) @(posedge mclk);
    chk("dones", n, n_done);
    chk("irqs_off", 2, n_irq);
    chk("irq_block", 0, blk);
    slow <= 1'b0;
    $display("test repeat done");
  endtask : t_repeat
  task automatic t_sources;
    logic [2:0] c;
    foreach (c_list[i]) begin
      c = c_list[i];
      apb(1'b1, 8'h0c, 1);
      set_ctrl(32'h80 | c);
      chk("irq_block", 1 << c, blk);
      chk("pair_mode", 0, pair);
      ev(c, c != 3'h7);
      rdc("ctrl", 8'h00, c);
    end
    set_ctrl(32'h80);
    rdc("ctrl", 8'h00, 32'h80);
    @(posedge mclk);
    standby <= 1'b1;
    @(posedge mclk);
    standby <= 1'b0;
    rdc("ctrl", 8'h00, 0);
    $display("test sources done");
  endtask : t_sources
  initial begin
    {rst_n, standby, psel, penable, pwrite, fire, hold, slow} = 8'h00;
    paddr  = 8'h00;
    pwdata = 32'h0;
    code   = 3'h0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs;
    t_io;
    t_idle;
    t_repeat;
    t_sources;
    report_and_stop;
  end
endmodule : dsc_short_channel_control_tb
